// *** core/cko_aux_ctrl.sv ***
// cko_aux_ctrl: auxiliary control, wake enables, baud-rate timer and the
// three toggling clock outputs, reached on an 8-bit sfr port.
// assumes timers 0/1 and the uarts sit outside and use the strobes here.
`timescale 1ns/1ns

// Notes on behaviour
// - three clock outputs from timer0, timer1, baud
// - timer0 ticks system_clock/12 or system_clock
// - timer1 ticks system_clock/12 or system_clock
// - uart1 mode0 rate system_clock/12 or /2
// - baud timer runs only when run set
// - uart2 rate doubled when bit set
// - baud timer advances every 12 or 1
// - aux ram below 0x0400 unless disabled
// - uart1 baud from timer1 or baud timer
// - counter-array pin wake when enabled
// - receive pin wake when enabled
// - timer1 pin wake when enabled
// - timer0 pin wake when enabled
// - low-voltage detect wake when enabled
// - baud pin toggles on baud overflow
// - timer1 pin toggles on timer1 overflow
// - timer0 pin toggles on timer0 overflow
// - reload register feeds baud timer
// - each overflow toggles latch, 50 percent
module cko_aux_ctrl (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// sfr port
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	// overflow pulses from timers 0 and 1
	input wire logic t0_ovf,
	input wire logic t1_ovf,
	// auxiliary ram address check
	input wire logic [15:0] xram_addr,
	output logic xram_onchip_sel,
	// wake sources from pins and interrupt logic (asynchronous)
	input wire logic [4:0] wake_req,
	output logic [4:0] wake_out,
	// timer and uart controls
	output logic timer0_tick,
	output logic timer1_tick,
	output logic serial_mode0_tick,
	output logic second_serial_rate_double,
	output logic first_serial_baud_source,
	output logic baud_timer_ovf,
	// clock pins
	output logic [2:0] clk_pin_out,
	output logic [2:0] clk_pin_oe
);
	typedef struct packed {
		logic [7:0] aux;
		logic [7:0] wake_and_clock_out_control;
		logic [7:0] reload;
		logic [7:0] rdata;
		logic [4:0] wake_sync;
		logic [4:0] wake_meta;
		logic [2:0] pin;
		logic [2:0] oe;
		logic [4:0] wake;
		logic ram_sel;
		logic t0_tick;
		logic t1_tick;
		logic m0_tick;
		logic s2_dbl;
		logic s1_src;
		logic bt_ovf;
	} cko_core_t;

	cko_core_t st_r;
	cko_core_t st_nxt;
	logic [2:0] ovf_src;

	cko_tick_if tk ();

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	cko_prescaler u_pre (
		.clk(clk),
		.sys_rst(sys_rst),
		.tk(tk.pre_src)
	);

	cko_baud_timer u_bt (
		.clk(clk),
		.sys_rst(sys_rst),
		.tk(tk.bt)
	);

	assign tk.bt_run = st_r.aux[cko_pkg::AUX_BT_RUN];
	assign tk.bt_bypass = st_r.aux[cko_pkg::AUX_BT_BYPASS];
	assign tk.bt_reload = st_r.reload;
	assign ovf_src = {tk.bt_ovf, t1_ovf, t0_ovf};

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		if (sfr_wr) begin
			if (sfr_addr == cko_pkg::AUX_CTRL_ADDR) begin
				st_nxt.aux = sfr_wdata;
			end else if (sfr_addr == cko_pkg::WAKE_AND_CLOCK_OUT_CONTROL_ADDR) begin
				st_nxt.wake_and_clock_out_control = sfr_wdata;
			end else if (sfr_addr == cko_pkg::BAUD_RELOAD_ADDR) begin
				st_nxt.reload = sfr_wdata;
			end
		end
		if (sfr_rd) begin
			if (sfr_addr == cko_pkg::AUX_CTRL_ADDR) begin
				st_nxt.rdata = st_r.aux;
			end else if (sfr_addr == cko_pkg::WAKE_AND_CLOCK_OUT_CONTROL_ADDR) begin
				st_nxt.rdata = st_r.wake_and_clock_out_control;
			end else if (sfr_addr == cko_pkg::BAUD_RELOAD_ADDR) begin
				st_nxt.rdata = st_r.reload;
			end else begin
				st_nxt.rdata = 8'h00;
			end
		end
		// timer prescale selects
		st_nxt.t0_tick = st_r.aux[cko_pkg::AUX_T0_BYPASS] | tk.tick_12;
		st_nxt.t1_tick = st_r.aux[cko_pkg::AUX_T1_BYPASS] | tk.tick_12;
		st_nxt.m0_tick = st_r.aux[cko_pkg::AUX_M0_FAST] ?
			tk.tick_2 : tk.tick_12;
		st_nxt.s2_dbl = st_r.aux[cko_pkg::AUX_S2_DOUBLE];
		st_nxt.s1_src = st_r.aux[cko_pkg::AUX_S1_SRC];
		st_nxt.bt_ovf = tk.bt_ovf;
		st_nxt.ram_sel = ~st_r.aux[cko_pkg::AUX_RAM_DIS] &
			(xram_addr <= cko_pkg::AUX_RAM_TOP);
		// wake gating: bit4..0 = counter array, rx, t1, t0, low voltage
		// pin wake requests pass two flops before the enable gate
		st_nxt.wake_meta = wake_req;
		st_nxt.wake_sync = st_r.wake_meta;
		st_nxt.wake = st_r.wake_sync &
			st_r.wake_and_clock_out_control[cko_pkg::WK_CA:cko_pkg::WK_LV];
		for (int i = 0; i < cko_pkg::NUM_CLKO; i++) begin
			st_nxt.oe[i] = st_r.wake_and_clock_out_control[i];
			if (!st_r.wake_and_clock_out_control[i]) begin
				st_nxt.pin[i] = 1'b0;
			end else if (ovf_src[i]) begin
				st_nxt.pin[i] = ~st_r.pin[i];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign sfr_rdata = st_r.rdata;
	assign xram_onchip_sel = st_r.ram_sel;
	assign wake_out = st_r.wake;
	assign timer0_tick = st_r.t0_tick;
	assign timer1_tick = st_r.t1_tick;
	assign serial_mode0_tick = st_r.m0_tick;
	assign second_serial_rate_double = st_r.s2_dbl;
	assign first_serial_baud_source = st_r.s1_src;
	assign baud_timer_ovf = st_r.bt_ovf;
	assign clk_pin_out = st_r.pin;
	assign clk_pin_oe = st_r.oe;
endmodule

// *** core/cko_baud_timer.sv ***
// cko_baud_timer: 8-bit auto-reload up-counter used as baud generator.
// assumes reload and control bits come from the register core.
`timescale 1ns/1ns
module cko_baud_timer (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// control and overflow
	cko_tick_if.bt tk
);
	typedef struct packed {
		logic [7:0] cnt;
		logic ovf;
	} cko_bt_t;

	cko_bt_t st_r;
	cko_bt_t st_nxt;
	logic adv;

	always_comb begin
		st_nxt = st_r;
		st_nxt.ovf = 1'b0;
		adv = tk.bt_run & (tk.bt_bypass | tk.tick_12);
		if (adv) begin
			if (st_r.cnt == 8'hff) begin
				st_nxt.cnt = tk.bt_reload;
				st_nxt.ovf = 1'b1;
			end else begin
				st_nxt.cnt = st_r.cnt + 8'h01;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign tk.bt_ovf = st_r.ovf;
endmodule

// *** core/cko_pkg.sv ***
// cko_pkg: register offsets, field positions, reset values and timing
// counts for the auxiliary control and clock-output block.
// assumes an 8-bit special-function-register port on the system clock.
package cko_pkg;
	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] AUX_CTRL_ADDR = 8'h8e;
	localparam logic [7:0] WAKE_AND_CLOCK_OUT_CONTROL_ADDR = 8'h8f;
	localparam logic [7:0] BAUD_RELOAD_ADDR = 8'h9c;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0] AUX_CTRL_RST = 8'h00;
	localparam logic [7:0] WAKE_AND_CLOCK_OUT_CONTROL_RST = 8'h00;
	localparam logic [7:0] BAUD_RELOAD_RST = 8'h00;

	// ------------------------------------------------------------
	// auxiliary control fields
	// ------------------------------------------------------------
	localparam int AUX_T0_BYPASS = 7;
	localparam int AUX_T1_BYPASS = 6;
	localparam int AUX_M0_FAST = 5;
	localparam int AUX_BT_RUN = 4;
	localparam int AUX_S2_DOUBLE = 3;
	localparam int AUX_BT_BYPASS = 2;
	localparam int AUX_RAM_DIS = 1;
	localparam int AUX_S1_SRC = 0;

	// ------------------------------------------------------------
	// wake and clock-out fields
	// ------------------------------------------------------------
	localparam int WK_CA = 7;
	localparam int WK_RX = 6;
	localparam int WK_T1 = 5;
	localparam int WK_T0 = 4;
	localparam int WK_LV = 3;
	localparam int CO_BT = 2;
	localparam int CO_T1 = 1;
	localparam int CO_T0 = 0;

	// ------------------------------------------------------------
	// timing counts
	// ------------------------------------------------------------
	localparam logic [3:0] DIV12_LAST = 4'hb;
	localparam logic [3:0] DIV2_LAST = 4'h1;
	localparam logic [15:0] AUX_RAM_TOP = 16'h03ff;
	localparam int NUM_CLKO = 3;
endpackage

// *** core/cko_prescaler.sv ***
// cko_prescaler: free-running divide-by-12 and divide-by-2 strobes.
// assumes synchronous active-high reset on clk.
`timescale 1ns/1ns
module cko_prescaler (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// strobes
	cko_tick_if.pre_src tk
);
	typedef struct packed {
		logic [3:0] cnt12;
		logic [3:0] cnt2;
		logic t12;
		logic t2;
	} cko_pre_t;

	cko_pre_t st_r;
	cko_pre_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.t12 = (st_r.cnt12 == cko_pkg::DIV12_LAST);
		st_nxt.t2 = (st_r.cnt2 == cko_pkg::DIV2_LAST);
		st_nxt.cnt12 = st_nxt.t12 ? 4'h0 : st_r.cnt12 + 4'h1;
		st_nxt.cnt2 = st_nxt.t2 ? 4'h0 : st_r.cnt2 + 4'h1;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign tk.tick_12 = st_r.t12;
	assign tk.tick_2 = st_r.t2;
endmodule

// *** core/cko_tick_if.sv ***
// cko_tick_if: prescale strobes and overflow pulses between the control
// core and its helper modules; all on the one system clock.
`timescale 1ns/1ns
interface cko_tick_if;
	logic tick_12;
	logic tick_2;
	logic bt_ovf;
	logic bt_run;
	logic bt_bypass;
	logic [7:0] bt_reload;

	modport pre_src (output tick_12, output tick_2);
	modport bt (input tick_12, input bt_run, input bt_bypass,
		input bt_reload, output bt_ovf);
	modport core (input tick_12, input tick_2, input bt_ovf,
		output bt_run, output bt_bypass, output bt_reload);
endinterface

// *** verification/cko_aux_properties.sv ***
// cko_aux_properties: port-level timing checks for cko_aux_ctrl.
// assumes a bind from the bench; one clock, synchronous reset.
`timescale 1ns/1ns
module cko_aux_properties (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// register writes, for the reload shadow
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	// watched ports
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_rdata,
	input wire logic t0_ovf,
	input wire logic [15:0] xram_addr,
	input wire logic xram_onchip_sel,
	input wire logic [4:0] wake_req,
	input wire logic [4:0] wake_out,
	input wire logic timer0_tick,
	input wire logic baud_timer_ovf,
	input wire logic [2:0] clk_pin_out,
	input wire logic [2:0] clk_pin_oe
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// a reload of all ones makes an overflow on every clock legal
	logic reload_ones;
	always @(posedge clk) begin
		if (sys_rst) begin
			reload_ones <= 1'b0;
		end else if (sfr_wr &&
			sfr_addr == cko_pkg::BAUD_RELOAD_ADDR) begin
			reload_ones <= (sfr_wdata == 8'hff);
		end
	end
	// --
	// assertions
	// --
	a_reset_clears: assert property (disable iff (1'b0) sys_rst |=>
		sfr_rdata == 8'h00 && clk_pin_out == 3'h0 && wake_out == 5'h00)
		else $error("outputs not cleared by reset");
	a_t0_tick_due: assert property (!timer0_tick |-> ##[1:14] timer0_tick)
		else $error("timer0 tick missing");
	a_wake_gated: assert property ((wake_out & ~$past(wake_req, 3)) == 5'h00)
		else $error("wake without request");
	a_ram_high_off: assert property ($past(xram_addr) > 16'h03ff |->
		!xram_onchip_sel) else $error("onchip ram above top");
	a_rdata_holds: assert property (!$past(sfr_rd) && !$past(sys_rst) |->
		$stable(sfr_rdata)) else $error("read data moved");
	a_pin_off_low: assert property (
		(clk_pin_out & ~clk_pin_oe & ~$past(clk_pin_oe)) == 3'h0)
		else $error("disabled pin not low");
	a_t0_pin_toggle: assert property (t0_ovf && clk_pin_oe[0] ##1
		clk_pin_oe[0] |-> ##[0:1] $changed(clk_pin_out[0]))
		else $error("timer0 pin did not toggle");
	a_baud_pin_toggle: assert property (baud_timer_ovf && clk_pin_oe[2] |->
		##[0:1] $changed(clk_pin_out[2])) else $error("baud pin still");
	a_ovf_one_cycle: assert property (baud_timer_ovf && !reload_ones |=>
		!baud_timer_ovf) else $error("baud overflow too long");
	c_baud_out: cover property (baud_timer_ovf && clk_pin_oe[2]);
	c_wake: cover property (|wake_out);
	c_ram_sel: cover property (xram_onchip_sel);
endmodule

// *** verification/cko_pin_watch.sv ***
// cko_pin_watch: load on the three clock pins, counting rising edges.
// assumes pins change only on the system clock.
`timescale 1ns/1ns
module cko_pin_watch (
	// clock
	input wire logic clk,
	// pins and count clear
	input wire logic [2:0] pins,
	input wire logic clr,
	// rise counts
	output int rises [3]
);
	logic [2:0] last_r;
	always @(posedge clk) begin
		last_r <= pins;
		for (int k = 0; k < 3; k++) begin
			rises[k] <= clr ? 0 : rises[k] + int'(pins[k] && !last_r[k]);
		end
	end
endmodule

// *** verification/tb.sv ***
// tb: registers, ticks, wake, ram select and clock outputs of cko_aux_ctrl.
// assumes core files, checker and pin watcher are compiled first.
`timescale 1ns/1ns
module tb;
	logic clk = 0, sys_rst = 1, sfr_wr = 0, sfr_rd = 0, clr = 1;
	logic t0_ovf = 0, t1_ovf = 0, xram_onchip_sel, baud_timer_ovf;
	logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
	logic [15:0] xram_addr = 16'h0000;
	logic [4:0] wake_req = 5'h00, wake_out;
	logic [2:0] clk_pin_out, clk_pin_oe;
	logic timer0_tick, timer1_tick, serial_mode0_tick;
	logic second_serial_rate_double, first_serial_baud_source;
	int rises [3];
	int failures = 0, comparisons = 0, cycles = 0;
	logic [23:0] rows [4] = '{24'h8ea5a5, 24'h8f5a5a, 24'h9c3c3c, 24'h8dff00};
	always #5 clk = ~clk;
	cko_aux_ctrl cko_aux_ctrl_i (.clk, .sys_rst, .sfr_addr, .sfr_wr, .sfr_rd,
		.sfr_wdata, .sfr_rdata, .t0_ovf, .t1_ovf, .xram_addr,
		.xram_onchip_sel, .wake_req, .wake_out, .timer0_tick, .timer1_tick,
		.serial_mode0_tick, .second_serial_rate_double,
		.first_serial_baud_source, .baud_timer_ovf, .clk_pin_out, .clk_pin_oe);
	cko_pin_watch cko_pin_watch_i (.clk, .pins(clk_pin_out), .clr, .rises);
	// --
	// tasks
	// --
	task automatic chk(logic [15:0] seen, logic [15:0] want);
		comparisons++;
		if (seen !== want) begin
			failures++;
			$display("BAD %0t seen %h want %h", $time, seen, want);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= 1;
		@(posedge clk);
		sfr_wr <= 0;
		@(posedge clk);
	endtask
	task automatic rdchk(logic [7:0] a, logic [7:0] want);
		sfr_addr <= a;
		sfr_rd <= 1;
		@(posedge clk);
		sfr_rd <= 0;
		@(posedge clk);
		chk(16'(sfr_rdata), 16'(want));
	endtask
	task automatic meas(int n, int w0, int wm, int wb, logic [11:0] wp);
		int c0 = 0, c1 = 0, cm = 0, cb = 0;
		clr <= 1;
		@(posedge clk);
		clr <= 0;
		for (int i = 0; i < n; i++) begin
			t0_ovf <= (i % 4 == 0);
			t1_ovf <= (i % 4 == 0);
			@(posedge clk);
			#1;
			c0 += timer0_tick;
			c1 += timer1_tick;
			cm += serial_mode0_tick;
			cb += baud_timer_ovf;
		end
		#1;
		chk(16'(c0), 16'(w0));
		chk(16'(c1), 16'(w0));
		chk(16'(cm), 16'(wm));
		chk(16'(cb), 16'(wb));
		chk({rises[0][3:0], rises[1][3:0], rises[2][3:0]}, wp);
		@(posedge clk);
	endtask
	task automatic complete_run;
		$display("counts: %0d compared, %0d bad", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		if (++cycles == 5000) begin
			failures++;
			complete_run;
		end
	end
	// --
	// tests
	// --
	initial begin
		repeat (4) @(posedge clk);
		sys_rst <= 0;
		@(posedge clk);
		rdchk(8'h8e, 8'h00);
		rdchk(8'h8f, 8'h00);
		rdchk(8'h9c, 8'h00);
		foreach (rows[k]) begin
			wr(rows[k][23:16], rows[k][15:8]);
			rdchk(rows[k][23:16], rows[k][7:0]);
		end
		$display("registers done");
		wr(8'h8f, 8'h07);
		wr(8'h9c, 8'hfe);
		wr(8'h8e, 8'h14);
		repeat (300) @(posedge clk);
		chk(16'(clk_pin_oe), 16'h0007);
		meas(24, 2, 2, 12, 12'h336);
		wr(8'h8e, 8'he0);
		repeat (4) @(posedge clk);
		meas(24, 24, 12, 0, 12'h330);
		wr(8'h8e, 8'h10);
		repeat (30) @(posedge clk);
		meas(48, 4, 4, 2, 12'h661);
		$display("ticks done");
		wr(8'h8f, 8'h98);
		wake_req <= 5'h1f;
		repeat (4) @(posedge clk);
		chk(16'(wake_out), 16'h0013);
		chk(16'(clk_pin_out | clk_pin_oe), 16'h0000);
		wake_req <= 5'h0c;
		repeat (4) @(posedge clk);
		chk(16'(wake_out), 16'h0000);
		wr(8'h8e, 8'h09);
		xram_addr <= 16'h03ff;
		repeat (3) @(posedge clk);
		chk({second_serial_rate_double, first_serial_baud_source,
			xram_onchip_sel}, 16'h0007);
		xram_addr <= 16'h0400;
		repeat (2) @(posedge clk);
		chk(16'(xram_onchip_sel), 16'h0000);
		wr(8'h8e, 8'h02);
		xram_addr <= 16'h0000;
		repeat (3) @(posedge clk);
		chk({second_serial_rate_double, first_serial_baud_source,
			xram_onchip_sel}, 16'h0000);
		$display("wake and ram done");
		sys_rst <= 1;
		repeat (2) @(posedge clk);
		sys_rst <= 0;
		@(posedge clk);
		rdchk(8'h8e, 8'h00);
		rdchk(8'h8f, 8'h00);
		rdchk(8'h9c, 8'h00);
		chk(16'(clk_pin_oe | wake_out), 16'h0000);
		$display("mid-run reset done");
		complete_run;
	end
endmodule
bind cko_aux_ctrl cko_aux_properties cko_aux_properties_i (.clk, .sys_rst,
	.sfr_wr, .sfr_addr, .sfr_wdata,
	.sfr_rd, .sfr_rdata, .t0_ovf, .xram_addr, .xram_onchip_sel, .wake_req,
	.wake_out, .timer0_tick, .baud_timer_ovf, .clk_pin_out, .clk_pin_oe);
